/* File: design/dma_channel_irq_and_src_reload.sv */
// one dma channel: error and transaction-done flags, irq levels, address control
// assumes transfer sequencer events are one-cycle pulses on I_CLK_SYS
// no vector-taken input: flags leave only through write-one clears or reset
`timescale 1ns/1ps
`include "dma_irq_map.svh"

// Overview of operation
// RULE1 - error flag survives vector entry, write-one clears
// RULE2 - transaction completion sets done flag, raises irq
// RULE3 - no repeat: block end completes transaction
// RULE4 - unlimited repeat: every block end sets done
// RULE5 - done flag survives vector entry, write-one clears
// RULE6 - error and done share one vector
// RULE7 - error level enables irq, requests while flag
// RULE8 - done level enables irq, requests while flag
// RULE9 - reload select: none, block, burst, transaction
// RULE10 - busy channel ignores reload field writes
// RULE11 - busy channel keeps source step mode
// RULE12 - level zero disables irq, flag still sets
module dma_channel_irq_and_src_reload (
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_RESET,
  input  wire logic                   I_CE,
  input  wire logic [3:0]             I_REG_ADDR,
  input  wire logic                   I_REG_WR,
  input  wire logic                   I_REG_RD,
  input  wire logic [7:0]             I_REG_WDATA,
  output logic      [7:0]             O_REG_RDATA,
  input  wire logic                   I_BUSY,
  input  wire logic                   I_BLOCK_END,
  input  wire logic                   I_BURST_END,
  input  wire logic                   I_TRANSACTION_END,
  input  wire logic                   I_REPEAT_EN,
  input  wire logic                   I_REPEAT_UNLIMITED,
  input  wire logic                   I_ERROR,
  output logic                        O_SRC_RELOAD,
  output logic      [7:0]             O_ADDR_CONTROL,
  output logic                        O_IRQ_REQ,
  output dma_irq_pkg::irq_level_t     O_IRQ_LEVEL
);
  import dma_irq_pkg::*;

  logic       err_flag_r;
  logic       done_flag_r;
  logic       err_flag_nxt;
  logic       done_flag_nxt;
  irq_level_t err_lvl_r;
  irq_level_t done_lvl_r;
  irq_level_t err_lvl_nxt;
  irq_level_t done_lvl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       wr_irq;
  logic       wr_addr;
  logic       clr_err;
  logic       clr_done;
  logic       done_evt;
  logic       err_req;
  logic       done_req;
  logic [7:0] irq_reg;

  addr_ctl_if actl ();

  // one decode for every strobe keeps the read and write maps in step
  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] offset);
    reg_hit = (addr == offset);
  endfunction

  // set beats a same-cycle write-one clear, so no event is ever lost
  function automatic logic flag_next(input logic flag,
                                     input logic set_in,
                                     input logic clr_in);
    flag_next = flag;
    if (set_in) begin
      flag_next = 1'b1;
    end else if (clr_in) begin
      flag_next = 1'b0;
    end
  endfunction

  // limited repeat leaves completion to the sequencer's transaction end
  function automatic logic done_event(input logic trn_end,
                                      input logic blk_end,
                                      input logic rep_en,
                                      input logic rep_unl);
    done_event = trn_end || (blk_end && (!rep_en || rep_unl));
  endfunction

  // a level field of zero masks the request but never the flag
  function automatic logic level_on(input logic       flag,
                                    input irq_level_t lvl);
    level_on = flag && (lvl != 2'h0);
  endfunction

  // shared vector: higher level wins, a tie goes to the error source
  function automatic irq_level_t pick_level(input logic       err_on,
                                            input irq_level_t err_lvl,
                                            input logic       done_on,
                                            input irq_level_t done_lvl);
    pick_level = 2'h0;
    if (err_on && (!done_on || err_lvl >= done_lvl)) begin
      pick_level = err_lvl;
    end else if (done_on) begin
      pick_level = done_lvl;
    end
  endfunction

  // bits 7:6 of the irq control byte read as zero
  function automatic logic [7:0] pack_irq(input logic       err_flag,
                                          input logic       done_flag,
                                          input irq_level_t err_lvl,
                                          input irq_level_t done_lvl);
    pack_irq                       = 8'h00;
    pack_irq[`ERR_FLAG_BIT]        = err_flag;
    pack_irq[`DONE_FLAG_BIT]       = done_flag;
    pack_irq[`ERR_LEVEL_LSB +: 2]  = err_lvl;
    pack_irq[`DONE_LEVEL_LSB +: 2] = done_lvl;
  endfunction

  // unmapped offsets read as zero
  function automatic logic [7:0] read_image(input logic [3:0] addr,
                                            input logic [7:0] irq_byte,
                                            input logic [7:0] ctl_byte);
    read_image = 8'h00;
    if (reg_hit(addr, `IRQ_CONTROL_OFFSET)) begin
      read_image = irq_byte;
    end else if (reg_hit(addr, `ADDR_CONTROL_OFFSET)) begin
      read_image = ctl_byte;
    end
  endfunction

  assign wr_irq   = I_REG_WR && reg_hit(I_REG_ADDR, `IRQ_CONTROL_OFFSET);
  assign wr_addr  = I_REG_WR && reg_hit(I_REG_ADDR, `ADDR_CONTROL_OFFSET);
  assign clr_err  = wr_irq && I_REG_WDATA[`ERR_FLAG_BIT];
  assign clr_done = wr_irq && I_REG_WDATA[`DONE_FLAG_BIT];

  // RULE2 explicit transaction end
  // RULE3 block end without repeat
  // RULE4 block end under unlimited repeat
  assign done_evt = done_event(I_TRANSACTION_END, I_BLOCK_END, I_REPEAT_EN,
                               I_REPEAT_UNLIMITED);

  // RULE1 set wins over write-one clear
  assign err_flag_nxt  = flag_next(err_flag_r, I_ERROR, clr_err);
  // RULE5 write-one clear, set wins
  assign done_flag_nxt = flag_next(done_flag_r, done_evt, clr_done);

  // levels load on every irq control write, even while busy
  assign err_lvl_nxt  = wr_irq ? I_REG_WDATA[`ERR_LEVEL_LSB +: 2] : err_lvl_r;
  assign done_lvl_nxt = wr_irq ? I_REG_WDATA[`DONE_LEVEL_LSB +: 2] : done_lvl_r;

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      err_flag_r <= 1'b0;
    end else if (I_CE) begin
      err_flag_r <= err_flag_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      done_flag_r <= 1'b0;
    end else if (I_CE) begin
      done_flag_r <= done_flag_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      err_lvl_r <= irq_level_t'(`IRQ_CONTROL_RESET >> `ERR_LEVEL_LSB);
    end else if (I_CE) begin
      err_lvl_r <= err_lvl_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      done_lvl_r <= irq_level_t'(`IRQ_CONTROL_RESET >> `DONE_LEVEL_LSB);
    end else if (I_CE) begin
      done_lvl_r <= done_lvl_nxt;
    end
  end

  // RULE7 error request while flagged
  // RULE12 zero level masks request
  assign err_req  = level_on(err_flag_r, err_lvl_r);
  // RULE8 done request while flagged
  assign done_req = level_on(done_flag_r, done_lvl_r);

  // RULE6 one shared vector, higher level wins
  assign O_IRQ_REQ   = err_req || done_req;
  assign O_IRQ_LEVEL = pick_level(err_req, err_lvl_r, done_req, done_lvl_r);

  assign irq_reg = pack_irq(err_flag_r, done_flag_r, err_lvl_r, done_lvl_r);

  assign rdata_nxt = read_image(I_REG_ADDR, irq_reg, actl.ctrl);

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      rdata_r <= 8'h00;
    end else if (I_CE && I_REG_RD) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign actl.wr        = wr_addr;
  assign actl.wdata     = I_REG_WDATA;
  assign actl.busy      = I_BUSY;
  assign actl.block_end = I_BLOCK_END;
  assign actl.burst_end = I_BURST_END;
  assign actl.trn_done  = done_evt;

  src_reload_ctl u_addr_ctl (
    .I_CLK_SYS (I_CLK_SYS),
    .I_RESET   (I_RESET),
    .i_ce      (I_CE),
    .bus       (actl)
  );

  assign O_REG_RDATA    = rdata_r;
  assign O_SRC_RELOAD   = actl.src_reload;
  assign O_ADDR_CONTROL = actl.ctrl;
endmodule

/* File: design/dma_irq_map.svh */
// offsets, field positions, reset values of one dma channel's irq and address control
// assumes byte-wide peripheral register space, channel-relative offsets
`ifndef DMA_IRQ_MAP_SVH
`define DMA_IRQ_MAP_SVH

`define IRQ_CONTROL_OFFSET    4'h1
`define ADDR_CONTROL_OFFSET   4'h2

`define IRQ_CONTROL_RESET     8'h00
`define ADDR_CONTROL_RESET    8'h00

`define ERR_FLAG_BIT          5
`define DONE_FLAG_BIT         4
`define ERR_LEVEL_LSB         2
`define DONE_LEVEL_LSB        0

`define SRC_RELOAD_LSB        6
`define SRC_STEP_LSB          4
`define DEST_FIELDS_LSB       0
`define DEST_FIELDS_WIDTH     4

`endif

/* File: design/dma_irq_pkg.sv */
// types shared by the dma channel irq and source reload logic
// assumes nothing beyond the map header
package dma_irq_pkg;

  typedef logic [1:0] irq_level_t;

  typedef enum logic [1:0] {
    RELOAD_NONE        = 2'h0,
    RELOAD_BLOCK       = 2'h1,
    RELOAD_BURST       = 2'h2,
    RELOAD_TRANSACTION = 2'h3
  } reload_sel_e;

endpackage

/* File: design/addr_ctl_if.sv */
// carrier between channel top and its address control register
// assumes both ends on the same clock
`timescale 1ns/1ps
interface addr_ctl_if;
  import dma_irq_pkg::*;
  logic       wr;
  logic [7:0] wdata;
  logic       busy;
  logic       block_end;
  logic       burst_end;
  logic       trn_done;
  logic [7:0] ctrl;
  logic       src_reload;

  modport ctl  (input wr, wdata, busy, block_end, burst_end, trn_done,
                output ctrl, src_reload);
  modport user (output wr, wdata, busy, block_end, burst_end, trn_done,
                input ctrl, src_reload);
endinterface

/* File: design/src_reload_ctl.sv */
// channel address control register with busy write protection and reload strobe
// assumes event inputs are one-cycle pulses on the same clock
`timescale 1ns/1ps
`include "dma_irq_map.svh"
module src_reload_ctl (
  input  wire logic   I_CLK_SYS,
  input  wire logic   I_RESET,
  input  wire logic   i_ce,
  addr_ctl_if.ctl     bus
);
  import dma_irq_pkg::*;

  logic [7:0]  ctrl_r;
  logic        reload_r;
  reload_sel_e sel;

  assign sel        = reload_sel_e'(ctrl_r[`SRC_RELOAD_LSB +: 2]);
  assign bus.ctrl   = ctrl_r;
  assign bus.src_reload = reload_r;

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_r <= `ADDR_CONTROL_RESET;
    end else if (i_ce && bus.wr) begin
      ctrl_r[`DEST_FIELDS_LSB +: `DEST_FIELDS_WIDTH] <=
        bus.wdata[`DEST_FIELDS_LSB +: `DEST_FIELDS_WIDTH];
      // RULE10 busy blocks reload write
      // RULE11 busy freezes step mode
      if (!bus.busy) begin
        ctrl_r[`SRC_RELOAD_LSB +: 2] <= bus.wdata[`SRC_RELOAD_LSB +: 2];
        ctrl_r[`SRC_STEP_LSB +: 2]   <= bus.wdata[`SRC_STEP_LSB +: 2];
      end
    end
  end

  // RULE9 reload point select
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      reload_r <= 1'b0;
    end else if (i_ce) begin
      case (sel)
        RELOAD_NONE:        reload_r <= 1'b0;
        RELOAD_BLOCK:       reload_r <= bus.block_end;
        RELOAD_BURST:       reload_r <= bus.burst_end;
        RELOAD_TRANSACTION: reload_r <= bus.trn_done;
        default:            reload_r <= 1'b0;
      endcase
    end
  end
endmodule

/* File: dv/dma_seq_model.sv */
// sequencer stand-in: busy level and one-cycle event pulses
// assumes callers start just after a rising edge
`timescale 1ns/1ps
module dma_seq_model (
  input  wire logic       I_CLK_SYS,
  output logic            o_busy,
  output logic      [3:0] o_ev
);
  initial {o_busy, o_ev} = 5'h00;
  task automatic hold(input logic b);
    o_busy = b;
  endtask
  // bit 0 block, 1 burst, 2 transaction, 3 error; high for one edge only
  task automatic pulse(input logic [3:0] e);
    o_ev = e;
    @(posedge I_CLK_SYS);
    #1 o_ev = 4'h0;
  endtask
endmodule

/* File: dv/dma_channel_irq_and_src_reload_properties.sv */
// port checker for the channel flags, levels and reload
// assumes bind onto the channel top, one clock
`timescale 1ns/1ps
module dma_chan_props (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RESET,
  input  wire logic       I_CE,
  input  wire logic [3:0] I_REG_ADDR,
  input  wire logic       I_REG_WR,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_BUSY,
  input  wire logic       I_BLOCK_END,
  input  wire logic       I_BURST_END,
  input  wire logic       I_TRANSACTION_END,
  input  wire logic       I_ERROR,
  input  wire logic       O_SRC_RELOAD,
  input  wire logic [7:0] O_ADDR_CONTROL,
  input  wire logic       O_IRQ_REQ,
  input  wire dma_irq_pkg::irq_level_t O_IRQ_LEVEL
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  wire logic [1:0] sel = O_ADDR_CONTROL[7:6];
  wire logic       clr = I_CE && I_REG_WR && I_REG_ADDR == 4'h1;
  wire logic       evt = I_CE && (I_ERROR || I_BLOCK_END || I_TRANSACTION_END);
  sequence s_ctl_wr;
    I_CE && I_REG_WR && I_REG_ADDR == 4'h2;
  endsequence
  a_reload_fire: assert property (I_CE && (sel == 2'h1 && I_BLOCK_END
    || sel == 2'h2 && I_BURST_END || sel == 2'h3 && I_TRANSACTION_END) |=> O_SRC_RELOAD)
    else $error("reload missing");
  a_reload_none: assert property (I_CE && sel == 2'h0 |=> !O_SRC_RELOAD)
    else $error("reload with none selected");
  a_busy_keep: assert property (s_ctl_wr ##0 I_BUSY |=> $stable(O_ADDR_CONTROL[7:4]))
    else $error("source fields changed while busy");
  a_ctl_load: assert property (s_ctl_wr ##0 !I_BUSY |=> O_ADDR_CONTROL == $past(I_REG_WDATA))
    else $error("control write lost");
  a_flag_hold: assert property (O_IRQ_REQ && !clr |=> O_IRQ_REQ)
    else $error("request dropped without clear");
  a_req_level: assert property (O_IRQ_REQ |-> O_IRQ_LEVEL != 2'h0)
    else $error("request at level zero");
  a_idle_level: assert property (!O_IRQ_REQ |-> O_IRQ_LEVEL == 2'h0)
    else $error("level without request");
  a_level_keep: assert property (O_IRQ_REQ && !clr && !evt |=> $stable(O_IRQ_LEVEL))
    else $error("level moved without cause");
endmodule
bind dma_channel_irq_and_src_reload dma_chan_props chk (.I_CLK_SYS, .I_RESET, .I_CE,
  .I_REG_ADDR, .I_REG_WR, .I_REG_WDATA, .I_BUSY, .I_BLOCK_END, .I_BURST_END,
  .I_TRANSACTION_END, .I_ERROR, .O_SRC_RELOAD, .O_ADDR_CONTROL, .O_IRQ_REQ, .O_IRQ_LEVEL);

/* File: dv/dma_channel_irq_and_src_reload_tb.sv */
// self-checking bench for one channel's flags, levels and address control
// assumes the sequencer stand-in and checker compile first
`timescale 1ns/1ps
module dma_channel_irq_and_src_reload_tb;
  logic       clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, rep = 0, unl = 0;
  logic [3:0] addr = 4'h0, ev;
  logic [7:0] wd = 8'h00, rdata, actl;
  logic       busy, reload, req;
  logic [1:0] lvl;
  int         n_errors = 0, checks = 0;
  dma_seq_model seq (.I_CLK_SYS(clk), .o_busy(busy), .o_ev(ev));
  dma_channel_irq_and_src_reload dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_CE(ce),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd), .O_REG_RDATA(rdata),
    .I_BUSY(busy), .I_BLOCK_END(ev[0]), .I_BURST_END(ev[1]), .I_TRANSACTION_END(ev[2]),
    .I_REPEAT_EN(rep), .I_REPEAT_UNLIMITED(unl), .I_ERROR(ev[3]), .O_SRC_RELOAD(reload),
    .O_ADDR_CONTROL(actl), .O_IRQ_REQ(req), .O_IRQ_LEVEL(lvl));
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  // extra edge at the end keeps strobes from toggling twice in one step
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    {wr, addr, wd} = {1'b1, a, d};
    cyc;
    wr = 0;
    cyc;
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    {rd, addr} = {1'b1, a};
    cyc;
    rd = 0;
    cyc;
    chk(n, rdata, e);
  endtask
  task automatic evc(input string n, input logic [3:0] e, input logic [7:0] x);
    seq.pulse(e);
    chk(n, {req, lvl}, x);
    cyc;
  endtask
  task automatic t_reset;
    rdc("ctl", 4'h2, 8'h00);
    rdc("irq", 4'h1, 8'h00);
    rdc("hole", 4'hf, 8'h00);
  endtask
  task automatic t_flags;
    wrt(4'h1, 8'h09);
    evc("err", 4'h8, 8'h06);
    wrt(4'h1, 8'h09);
    rdc("err kept", 4'h1, 8'h29);
    wrt(4'h1, 8'h29);
    evc("blk", 4'h1, 8'h05);
    rdc("done kept", 4'h1, 8'h19);
    evc("both", 4'h8, 8'h06);
    wrt(4'h1, 8'h39);
    {rep, unl} = 2'h3;
    evc("unl blk", 4'h1, 8'h05);
    wrt(4'h1, 8'h19);
    unl = 0;
    evc("rep blk", 4'h1, 8'h00);
    evc("trn", 4'h4, 8'h05);
    wrt(4'h1, 8'h30);
    evc("lvl0", 4'h8, 8'h00);
    rdc("lvl0 flag", 4'h1, 8'h20);
    wrt(4'h1, 8'h20);
  endtask
  task automatic t_reload;
    for (int s = 0; s < 4; s++) begin
      wrt(4'h2, 8'(s << 6));
      for (int k = 0; k < 3; k++) begin
        seq.pulse(4'(1 << k));
        chk("reload", reload, 8'(s == k + 1));
        cyc;
        chk("reload end", reload, 8'h00);
      end
    end
  endtask
  task automatic t_busy;
    wrt(4'h2, 8'h60);
    seq.hold(1);
    wrt(4'h2, 8'hff);
    chk("busy", actl, 8'h6f);
    seq.hold(0);
    wrt(4'h2, 8'h9c);
    rdc("idle", 4'h2, 8'h9c);
  endtask
  // enable low freezes flags, control and reload; then a reset mid-run
  task automatic t_hold;
    wrt(4'h1, 8'h37);
    ce = 0;
    evc("ce err", 4'h8, 8'h00);
    seq.pulse(4'h2);
    chk("ce reload", reload, 8'h00);
    wrt(4'h2, 8'h00);
    chk("ce ctl", actl, 8'h9c);
    ce = 1;
    evc("done hi", 4'h4, 8'h07);
    evc("pri", 4'h8, 8'h07);
    rst = 1;
    cyc;
    rst = 0;
    chk("rst req", {req, lvl}, 8'h00);
    chk("rst ctl", actl, 8'h00);
    evc("rst lvl", 4'h8, 8'h00);
    rdc("rst flag", 4'h1, 8'h20);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (10) cyc;
    rst = 0;
    t_reset;
    t_flags;
    t_reload;
    t_busy;
    t_hold;
    wrap_up;
  end
endmodule
